/* rtl/tpw_pkg.sv */
// Shared constants for the 8-bit PWM timer block
package tpw_pkg;

  // Register bus geometry
  localparam int unsigned TPW_AW = 3;
  localparam int unsigned TPW_DW = 8;

  // Register indices on the plain register port
  localparam logic [2:0] TPW_A_CTRL = 3'h0;
  localparam logic [2:0] TPW_A_OUTCFG = 3'h1;
  localparam logic [2:0] TPW_A_CMPA = 3'h2;
  localparam logic [2:0] TPW_A_CMPB = 3'h3;
  localparam logic [2:0] TPW_A_COUNT = 3'h4;
  localparam logic [2:0] TPW_A_FLAGS = 3'h5;
  localparam logic [2:0] TPW_A_STATUS = 3'h6;

  // Control register field positions
  localparam int unsigned TPW_CTRL_MODE_LSB = 0;
  localparam int unsigned TPW_CTRL_CSEL_LSB = 3;
  localparam int unsigned TPW_CTRL_ASYNC_BIT = 6;

  // Output configuration field positions
  localparam int unsigned TPW_OC_COMA_LSB = 0;
  localparam int unsigned TPW_OC_COMB_LSB = 2;
  localparam int unsigned TPW_OC_DIRA_BIT = 4;
  localparam int unsigned TPW_OC_DIRB_BIT = 5;
  localparam int unsigned TPW_OC_PORTA_BIT = 6;
  localparam int unsigned TPW_OC_PORTB_BIT = 7;

  // Flag and status field positions
  localparam int unsigned TPW_FL_OVF_BIT = 0;
  localparam int unsigned TPW_FL_MFA_BIT = 1;
  localparam int unsigned TPW_FL_MFB_BIT = 2;
  localparam int unsigned TPW_ST_PRST_BIT = 0;

  // Reset values
  localparam logic [7:0] TPW_RST_CTRL = 8'h00;
  localparam logic [7:0] TPW_RST_OUTCFG = 8'h00;
  localparam logic [7:0] TPW_RST_CMP = 8'h00;
  localparam logic [7:0] TPW_RST_COUNT = 8'h00;

  // Counter limits
  localparam logic [7:0] TPW_BOTTOM = 8'h00;
  localparam logic [7:0] TPW_MAX = 8'hff;

  // Waveform mode field encodings
  localparam logic [2:0] TPW_M_NORMAL = 3'h0;
  localparam logic [2:0] TPW_M_PC_FF = 3'h1;
  localparam logic [2:0] TPW_M_CTC = 3'h2;
  localparam logic [2:0] TPW_M_FAST_FF = 3'h3;
  localparam logic [2:0] TPW_M_PC_A = 3'h5;
  localparam logic [2:0] TPW_M_FAST_A = 3'h7;

  // Compare output mode encodings
  localparam logic [1:0] TPW_COM_OFF = 2'h0;
  localparam logic [1:0] TPW_COM_TOGGLE = 2'h1;
  localparam logic [1:0] TPW_COM_NONINV = 2'h2;
  localparam logic [1:0] TPW_COM_INV = 2'h3;

  // Prescaler divide masks: tick when the masked count bits are all ones
  localparam logic [9:0] TPW_DIV1_MASK = 10'h000;
  localparam logic [9:0] TPW_DIV8_MASK = 10'h007;
  localparam logic [9:0] TPW_DIV32_MASK = 10'h01f;
  localparam logic [9:0] TPW_DIV64_MASK = 10'h03f;
  localparam logic [9:0] TPW_DIV128_MASK = 10'h07f;
  localparam logic [9:0] TPW_DIV256_MASK = 10'h0ff;
  localparam logic [9:0] TPW_DIV1024_MASK = 10'h3ff;

  // Counting direction
  typedef enum logic {TPW_UP, TPW_DOWN} tpw_dir_e;

endpackage

/* rtl/tpw_timer8_pwm.sv */
// 8-bit timer with fast and phase correct PWM on two compare channels
//
// Added by the designer: the plain strobed port and the register addresses.
`timescale 1ns/10ps
`default_nettype none

// Operation
// - Fast PWM counts up, restarts at BOTTOM
// - Fast PWM TOP: 0xFF or compare A
// - At TOP, counter clears next tick
// - Fast: match clears, BOTTOM sets; inverse inverted
// - Output mode two non-inverted, three inverted
// - Fast PWM overflow flag at TOP
// - Fixed TOP fast period 256 ticks
// - Prescale 1,8,32,64,128,256,1024 selectable
// - Compare BOTTOM spike, MAX constant level
// - Output mode one toggles on match; phase correct ignores it and holds the level
// - Pin driven only when direction is output
// - Phase correct counts up then down
// - Phase correct TOP: compare A or 0xFF
// - TOP held one tick, then reverse
// - Phase correct: clear up, set down
// - Phase correct overflow flag at BOTTOM
// - Fixed TOP phase correct period 510 ticks
// - Phase correct extremes give constant levels
// - Leaving MAX forces up result at BOTTOM
// - Missed up match forces transition at BOTTOM
// - Timer tick is clock enable, oscillator optional
// - Output mode zero leaves pin to port
module tpw_timer8_pwm
  import tpw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [TPW_AW-1:0] i_addr,
  input wire logic [TPW_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [TPW_DW-1:0] o_rdata,
  input wire logic i_osc,
  output logic o_pin_a,
  output logic o_pin_a_oe,
  output logic o_pin_b,
  output logic o_pin_b_oe
);

  // Mode family decoders; reserved codes fall to non-PWM behaviour
  // Fast PWM family
  function automatic logic is_fast(input logic [2:0] m);
    is_fast = (m == TPW_M_FAST_FF) || (m == TPW_M_FAST_A);
  endfunction

  // Phase correct family
  function automatic logic is_pc(input logic [2:0] m);
    is_pc = (m == TPW_M_PC_FF) || (m == TPW_M_PC_A);
  endfunction

  // Prescaler tap select; zero stops the timer
  function automatic logic div_hit(input logic [2:0] sel, input logic [9:0] cnt);
    logic [9:0] mask;
    mask = TPW_DIV1_MASK;
    case (sel)
      3'h1: mask = TPW_DIV1_MASK;
      3'h2: mask = TPW_DIV8_MASK;
      3'h3: mask = TPW_DIV32_MASK;
      3'h4: mask = TPW_DIV64_MASK;
      3'h5: mask = TPW_DIV128_MASK;
      3'h6: mask = TPW_DIV256_MASK;
      3'h7: mask = TPW_DIV1024_MASK;
      default: mask = TPW_DIV1_MASK;
    endcase
    div_hit = (sel != 3'h0) && ((cnt & mask) == mask);
  endfunction

  // Oscillator synchroniser and prescaler state
  logic osc_s1_q, osc_s2_q, osc_s3_q, osc_lvl_q;
  logic osc_lvl_d;
  logic [9:0] pre_q, pre_d;
  logic ref_pulse, tick;

  // Software visible state
  // Only the flags and the counter see both hardware and software writes
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] outcfg_q, outcfg_d;
  // Per-channel arrays, index 0 is channel A
  logic [7:0] buf_q [2];
  logic [7:0] buf_d [2];
  logic [7:0] act_q [2];
  logic [7:0] act_d [2];
  logic [7:0] cnt_q, cnt_d;
  logic [2:0] flags_q, flags_d;
  logic [7:0] rdata_d;

  // Waveform state
  // Up-count match memory feeds the symmetry fix at BOTTOM
  tpw_dir_e dir_q, dir_d;
  logic [1:0] oc_q, oc_d;
  logic [1:0] hit_q, hit_d;
  logic blk_q, blk_d;

  // Decoded controls
  // Combinational decodes, derived from registered state and the bus write strobes
  logic [2:0] mode;
  logic [1:0] com [2];
  logic fast, pc, wrap, bot, at_top, load;
  logic [7:0] top;
  logic [1:0] match;
  logic wr_ctrl, wr_count, wr_flags, pre_rst;
  // Hardware flag sets of this cycle, merged after any clear
  logic [2:0] fset;

  // Output mode changes act at once; they are not buffered
  assign mode = ctrl_q[TPW_CTRL_MODE_LSB +: 3];
  assign com[0] = outcfg_q[TPW_OC_COMA_LSB +: 2];
  assign com[1] = outcfg_q[TPW_OC_COMB_LSB +: 2];
  assign fast = is_fast(mode);
  assign pc = is_pc(mode);
  assign wr_ctrl = i_wr && (i_addr == TPW_A_CTRL);
  assign wr_count = i_wr && (i_addr == TPW_A_COUNT);
  assign wr_flags = i_wr && (i_addr == TPW_A_FLAGS);
  assign pre_rst = i_wr && (i_addr == TPW_A_STATUS) && i_wdata[TPW_ST_PRST_BIT];

  // TOP follows compare A in its modes, else fixed MAX
  // Active copy is used, so TOP only moves at a buffer load
  always_comb begin
    if (mode == TPW_M_FAST_A || mode == TPW_M_CTC) begin
      top = act_q[0];
    end else if (mode == TPW_M_PC_A) begin
      top = act_q[0];
    end else begin
      top = TPW_MAX;
    end
  end

  // Oscillator edge detect only trusts stages two and three agreeing
  always_comb begin
    osc_lvl_d = osc_lvl_q;
    if (osc_s2_q == osc_s3_q) begin
      osc_lvl_d = osc_s3_q;
    end
    // Reference is the I/O clock or a settled oscillator rise
    ref_pulse = ctrl_q[TPW_CTRL_ASYNC_BIT] ? (osc_s2_q && osc_s3_q && !osc_lvl_q) : 1'b1;
    // Stopped select freezes the prescaler as well
    pre_d = pre_q;
    if (pre_rst) begin
      pre_d = 10'h000;
    end else if (ref_pulse && ctrl_q[TPW_CTRL_CSEL_LSB +: 3] != 3'h0) begin
      pre_d = pre_q + 10'h001;
    end
    // Tick is a one-cycle enable, never a derived clock
    tick = ref_pulse && div_hit(ctrl_q[TPW_CTRL_CSEL_LSB +: 3], pre_q);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      osc_lvl_q <= 1'b0;
      pre_q <= 10'h000;
    end else if (i_ce) begin
      osc_s1_q <= i_osc;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      osc_lvl_q <= osc_lvl_d;
      pre_q <= pre_d;
    end
  end

  // Counter, compare, waveform and register next state
  always_comb begin
    ctrl_d = wr_ctrl ? i_wdata : ctrl_q;
    outcfg_d = (i_wr && i_addr == TPW_A_OUTCFG) ? i_wdata : outcfg_q;
    cnt_d = cnt_q;
    dir_d = dir_q;
    blk_d = blk_q;
    flags_d = flags_q;
    oc_d = oc_q;
    hit_d = hit_q;
    wrap = 1'b0;
    bot = 1'b0;
    at_top = 1'b0;
    load = 1'b0;
    match = 2'b00;
    fset = 3'h0;
    for (int ch = 0; ch < 2; ch++) begin
      buf_d[ch] = buf_q[ch];
      act_d[ch] = act_q[ch];
    end
    // Software writes only the buffer; the active copy waits for a load
    if (i_wr && i_addr == TPW_A_CMPA) begin
      buf_d[0] = i_wdata;
    end
    if (i_wr && i_addr == TPW_A_CMPB) begin
      buf_d[1] = i_wdata;
    end
    if (tick) begin
      blk_d = 1'b0;
      if (pc) begin
        // Dual slope; TOP and BOTTOM each held one tick
        // Limitation: a TOP of zero parks the counter at BOTTOM
        if (dir_q == TPW_UP) begin
          if (cnt_q == top) begin
            at_top = 1'b1;
            dir_d = TPW_DOWN;
            cnt_d = (top == TPW_BOTTOM) ? TPW_BOTTOM : cnt_q - 8'h01;
          end else begin
            cnt_d = cnt_q + 8'h01;
          end
        end else begin
          if (cnt_q == TPW_BOTTOM) begin
            bot = 1'b1;
            dir_d = TPW_UP;
            cnt_d = (top == TPW_BOTTOM) ? TPW_BOTTOM : 8'h01;
          end else begin
            cnt_d = cnt_q - 8'h01;
          end
        end
      end else begin
        // Single slope; fixed TOP gives 256 ticks per period
        // Hazard: a TOP below the count runs on to MAX before wrapping
        dir_d = TPW_UP;
        if (cnt_q == top) begin
          wrap = 1'b1;
          cnt_d = TPW_BOTTOM;
        end else begin
          cnt_d = cnt_q + 8'h01;
        end
      end
      // Overflow at TOP in single slope, BOTTOM in phase correct
      // Flags set only on a tick; software clears them with ones
      if (pc ? bot : wrap) begin
        fset[TPW_FL_OVF_BIT] = 1'b1;
      end
      // Match uses the active compare, blocked after a count write
      for (int ch = 0; ch < 2; ch++) begin
        match[ch] = (cnt_q == act_q[ch]) && !blk_q;
      end
      if (match[0]) begin
        fset[TPW_FL_MFA_BIT] = 1'b1;
      end
      if (match[1]) begin
        fset[TPW_FL_MFB_BIT] = 1'b1;
      end
    end
    // Buffered compare lands at BOTTOM (fast) or TOP (phase correct)
    // Non-PWM modes have no buffering, so they load at once
    load = fast ? wrap : (pc ? at_top : 1'b1);
    for (int ch = 0; ch < 2; ch++) begin
      if (load) begin
        act_d[ch] = buf_q[ch];
      end
    end
    // Output compare level per channel
    // Trade-off: phase correct ignores toggle mode rather than guess
    for (int ch = 0; ch < 2; ch++) begin
      if (com[ch] == TPW_COM_OFF) begin
        oc_d[ch] = oc_q[ch];
      end else if (fast) begin
        if (match[ch]) begin
          case (com[ch])
            TPW_COM_TOGGLE: oc_d[ch] = !oc_q[ch];
            TPW_COM_NONINV: oc_d[ch] = 1'b0;
            TPW_COM_INV: oc_d[ch] = 1'b1;
            default: oc_d[ch] = oc_q[ch];
          endcase
        end
        // BOTTOM action wins so MAX compare gives a steady level
        if (wrap && com[ch] != TPW_COM_TOGGLE) begin
          oc_d[ch] = (com[ch] == TPW_COM_NONINV);
        end
      end else if (pc) begin
        if (com[ch] != TPW_COM_TOGGLE) begin
          // Match at TOP counts as down, at BOTTOM as up
          if (match[ch]) begin
            if (dir_d == TPW_UP) begin
              oc_d[ch] = (com[ch] == TPW_COM_INV);
            end else begin
              oc_d[ch] = (com[ch] == TPW_COM_NONINV);
            end
          end else if (bot && !hit_q[ch] && act_q[ch] != top) begin
            oc_d[ch] = (com[ch] == TPW_COM_INV);
          end
        end
      end else if (match[ch]) begin
        case (com[ch])
          TPW_COM_TOGGLE: oc_d[ch] = !oc_q[ch];
          TPW_COM_NONINV: oc_d[ch] = 1'b0;
          TPW_COM_INV: oc_d[ch] = 1'b1;
          default: oc_d[ch] = oc_q[ch];
        endcase
      end
      // Remember an up-slope match until the next BOTTOM
      // Missed-match tracking drives the forced transition at BOTTOM
      hit_d[ch] = (bot ? 1'b0 : hit_q[ch]) | (match[ch] && dir_d == TPW_UP);
    end
    // Software count write overrides and masks the next match
    // Blocking lets compare equal the written count without a flag
    if (wr_count) begin
      cnt_d = i_wdata;
      blk_d = 1'b1;
    end
    // Hardware set wins over write-one-to-clear, even on a set flag
    flags_d = (wr_flags ? (flags_q & ~i_wdata[2:0]) : flags_q) | fset;
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ctrl_q <= TPW_RST_CTRL;
      outcfg_q <= TPW_RST_OUTCFG;
      buf_q[0] <= TPW_RST_CMP;
      buf_q[1] <= TPW_RST_CMP;
      act_q[0] <= TPW_RST_CMP;
      act_q[1] <= TPW_RST_CMP;
      cnt_q <= TPW_RST_COUNT;
      dir_q <= TPW_UP;
      flags_q <= 3'h0;
      oc_q <= 2'b00;
      hit_q <= 2'b00;
      blk_q <= 1'b0;
    end else if (i_ce) begin
      ctrl_q <= ctrl_d;
      outcfg_q <= outcfg_d;
      buf_q[0] <= buf_d[0];
      buf_q[1] <= buf_d[1];
      act_q[0] <= act_d[0];
      act_q[1] <= act_d[1];
      cnt_q <= cnt_d;
      dir_q <= dir_d;
      flags_q <= flags_d;
      oc_q <= oc_d;
      hit_q <= hit_d;
      blk_q <= blk_d;
    end
  end

  // Read mux; unmapped addresses return zero
  // Registered, so data stand only in the cycle after the strobe
  always_comb begin
    rdata_d = 8'h00;
    if (i_rd) begin
      case (i_addr)
        TPW_A_CTRL: rdata_d = ctrl_q;
        TPW_A_OUTCFG: rdata_d = outcfg_q;
        TPW_A_CMPA: rdata_d = buf_q[0];
        TPW_A_CMPB: rdata_d = buf_q[1];
        TPW_A_COUNT: rdata_d = cnt_q;
        TPW_A_FLAGS: rdata_d = {5'h00, flags_q};
        TPW_A_STATUS: rdata_d = {5'h00, (dir_q == TPW_DOWN), oc_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else if (i_ce) begin
      o_rdata <= rdata_d;
    end
  end

  // Pin mux: port bit unless an output mode overrides; direction gates drive
  // Compare level can be preset before the driver is enabled
  always_comb begin
    o_pin_a = (com[0] != TPW_COM_OFF) ? oc_q[0] : outcfg_q[TPW_OC_PORTA_BIT];
    o_pin_b = (com[1] != TPW_COM_OFF) ? oc_q[1] : outcfg_q[TPW_OC_PORTB_BIT];
    o_pin_a_oe = outcfg_q[TPW_OC_DIRA_BIT];
    o_pin_b_oe = outcfg_q[TPW_OC_DIRB_BIT];
  end

endmodule

`default_nettype wire

/* dv/tpw_timer8_pwm_sva.sv */
// Port-level assertions for the 8-bit PWM timer
`timescale 1ns/10ps
`default_nettype none
module tpw_timer8_pwm_sva
  import tpw_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic i_ce,
  input wire logic [TPW_AW-1:0] i_addr,
  input wire logic [TPW_DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [TPW_DW-1:0] o_rdata,
  input wire logic o_pin_a,
  input wire logic o_pin_a_oe,
  input wire logic o_pin_b,
  input wire logic o_pin_b_oe
);
  logic [7:0] ctrl_q, outc_q, cmpa_q;
  logic [9:0] settle_q;
  logic cfg_wr, cnt_wr;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  // Accepted writes to output config and counter
  assign cfg_wr = i_ce && i_wr && i_addr == TPW_A_OUTCFG;
  assign cnt_wr = i_ce && i_wr && i_addr == TPW_A_COUNT;
  // Shadow config; settle counts quiet cycles so steady levels are judged late
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ctrl_q <= 8'h00;
      outc_q <= 8'h00;
      cmpa_q <= 8'h00;
      settle_q <= 10'h000;
    end else if (i_ce) begin
      if (i_wr && i_addr == TPW_A_CTRL)
        ctrl_q <= i_wdata;
      if (cfg_wr)
        outc_q <= i_wdata;
      if (i_wr && i_addr == TPW_A_CMPA)
        cmpa_q <= i_wdata;
      settle_q <= (i_wr && i_addr <= TPW_A_COUNT) ? 10'h000
        : settle_q + {9'h000, settle_q != 10'h3ff};
    end
  end
  property p_rd_idle;
    i_ce && !i_rd |=> o_rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  property p_dir_a;
    cfg_wr |=> o_pin_a_oe == $past(i_wdata[TPW_OC_DIRA_BIT]);
  endproperty
  a_dir_a: assert property (p_dir_a) else $error("pin a enable wrong");
  property p_dir_b;
    cfg_wr |=> o_pin_b_oe == $past(i_wdata[TPW_OC_DIRB_BIT]);
  endproperty
  a_dir_b: assert property (p_dir_b) else $error("pin b enable wrong");
  property p_port_a;
    cfg_wr && i_wdata[1:0] == TPW_COM_OFF |=> o_pin_a == $past(i_wdata[TPW_OC_PORTA_BIT]);
  endproperty
  a_port_a: assert property (p_port_a) else $error("pin a not port level");
  property p_port_b;
    cfg_wr && i_wdata[3:2] == TPW_COM_OFF |=> o_pin_b == $past(i_wdata[TPW_OC_PORTB_BIT]);
  endproperty
  a_port_b: assert property (p_port_b) else $error("pin b not port level");
  property p_stop_cnt;
    i_ce && i_rd && i_addr == TPW_A_COUNT && ctrl_q[5:3] == 3'h0 && $past(cnt_wr, 2)
      |=> o_rdata == $past(i_wdata, 3);
  endproperty
  a_stop_cnt: assert property (p_stop_cnt) else $error("stopped counter moved");
  property p_ce_hold;
    !i_ce |=> $stable(o_rdata) && $stable(o_pin_a) && $stable(o_pin_b);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("outputs moved without enable");
  property p_pc_min;
    settle_q == 10'h3ff && ctrl_q[6:0] == 7'h09 && outc_q[1:0] == TPW_COM_NONINV
      && cmpa_q == 8'h00 |-> o_pin_a == 1'b0;
  endproperty
  a_pc_min: assert property (p_pc_min) else $error("dual slope zero not low");
  property p_fast_max;
    settle_q == 10'h3ff && ctrl_q[6:0] == 7'h0b && outc_q[1:0] == TPW_COM_NONINV
      && cmpa_q == 8'hff |-> o_pin_a == 1'b1;
  endproperty
  a_fast_max: assert property (p_fast_max) else $error("single slope max not high");
endmodule
bind tpw_timer8_pwm tpw_timer8_pwm_sva tpw_timer8_pwm_sva_i (.i_clk(i_clk), .i_rst_b(i_rst_b),
  .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
  .o_rdata(o_rdata), .o_pin_a(o_pin_a), .o_pin_a_oe(o_pin_a_oe), .o_pin_b(o_pin_b),
  .o_pin_b_oe(o_pin_b_oe));
`default_nettype wire

/* dv/test_tpw_timer8_pwm.sv */
// Self-checking bench for the 8-bit PWM timer
`timescale 1ns/10ps
`default_nettype none
module test_tpw_timer8_pwm;
  import tpw_pkg::*;
  logic i_clk = 1'b0, i_rst_b = 1'b0, i_ce = 1'b1, i_wr = 1'b0, i_rd = 1'b0, rd_seen = 1'b0;
  logic [2:0] i_addr = 3'h0;
  logic [7:0] i_wdata = 8'h00, o_rdata, d;
  logic o_pin_a, o_pin_a_oe, o_pin_b, o_pin_b_oe;
  logic [7:0] exp_q[$];
  int err_total = 0, n_compared = 0, cyc = 0, hi, per, seed;
  int divs[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
  // 125 MHz clock
  always #4 i_clk = ~i_clk;
  tpw_timer8_pwm tpw_timer8_pwm_i (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(i_ce),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_osc(1'b0), .o_pin_a(o_pin_a), .o_pin_a_oe(o_pin_a_oe), .o_pin_b(o_pin_b),
    .o_pin_b_oe(o_pin_b_oe));
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared=%0d errors=%0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Bus cycles; the trailing idle edge keeps strobes from being reassigned
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] v);
    exp_q.push_back(v);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(posedge i_clk);
  endtask
  // Read data stand only in the cycle after the strobe
  always @(posedge i_clk) rd_seen <= i_rd & i_ce;
  always @(negedge i_clk) begin
    if (rd_seen)
      chk(o_rdata, exp_q.pop_front());
  end
  function automatic logic pv(input bit b);
    return b ? o_pin_b : o_pin_a;
  endfunction
  // High time and period of one pin, sampled mid-cycle
  task automatic meas(input bit b, input int n);
    repeat (n) begin
      @(negedge i_clk);
      while (pv(b) !== 1'b0) @(negedge i_clk);
      while (pv(b) !== 1'b1) @(negedge i_clk);
      hi = 0;
      while (pv(b) === 1'b1) begin
        @(negedge i_clk);
        hi++;
      end
      per = hi;
      while (pv(b) === 1'b0) begin
        @(negedge i_clk);
        per++;
      end
    end
    @(posedge i_clk);
  endtask
  task automatic hold(input bit b, input logic v);
    repeat (1100) @(negedge i_clk);
    chk(pv(b), v);
    @(posedge i_clk);
  endtask
  // Hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 90000) begin
      err_total++;
      give_verdict();
    end
  end
  initial begin
    seed = 32'h43fa;
    repeat (5) @(posedge i_clk);
    i_rst_b <= 1'b1;
    for (int a = 0; a < 8; a++) rd(a[2:0], 8'h00);
    wr(TPW_A_COUNT, 8'h5a);
    rd(TPW_A_COUNT, 8'h5a);
    wr(TPW_A_OUTCFG, 8'h50);
    @(negedge i_clk);
    chk({o_pin_a_oe, o_pin_a}, 16'h3);
    @(posedge i_clk);
    wr(TPW_A_OUTCFG, 8'h3a);
    wr(TPW_A_CTRL, 8'h0b);
    repeat (3) begin
      d = 8'($random(seed));
      d = (d == 8'h00 || d == 8'hff) ? 8'h80 : d;
      wr(TPW_A_CMPA, d);
      meas(0, 1);
      chk(hi, d + 16'h1);
      chk(per, 16'h100);
    end
    wr(TPW_A_OUTCFG, 8'h3b);
    meas(0, 1);
    chk(hi, 16'hff - d);
    i_ce <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_ce <= 1'b1;
    rd(TPW_A_FLAGS, 8'h07);
    wr(TPW_A_OUTCFG, 8'h3a);
    wr(TPW_A_CMPA, 8'h00);
    meas(0, 2);
    chk(hi, 16'h1);
    wr(TPW_A_CMPA, 8'hff);
    hold(0, 1'b1);
    wr(TPW_A_CMPA, 8'h3f);
    wr(TPW_A_CMPB, 8'h10);
    wr(TPW_A_CTRL, 8'h0f);
    meas(1, 2);
    chk(per, 16'h40);
    chk(hi, 16'h11);
    // Toggle on a 4-tick frame, every prescale choice
    wr(TPW_A_CMPA, 8'h03);
    wr(TPW_A_OUTCFG, 8'h39);
    for (int c = 1; c < 8; c++) begin
      wr(TPW_A_CTRL, 8'h07 | 8'(c << 3));
      meas(0, 1);
      chk(per, 16'(8 * divs[c]));
    end
    wr(TPW_A_OUTCFG, 8'h3a);
    wr(TPW_A_CMPA, 8'h40);
    wr(TPW_A_CTRL, 8'h09);
    meas(0, 2);
    chk(per, 16'h1fe);
    chk(hi, 16'h80);
    wr(TPW_A_CMPA, 8'h3f);
    wr(TPW_A_CTRL, 8'h0d);
    meas(1, 2);
    chk(per, 16'h7e);
    chk(hi, 16'h20);
    wr(TPW_A_CTRL, 8'h09);
    wr(TPW_A_CMPA, 8'h00);
    hold(0, 1'b0);
    wr(TPW_A_CMPA, 8'hff);
    hold(0, 1'b1);
    give_verdict();
  end
endmodule
`default_nettype wire
